// ---- src/iic_irq_gating_defs.vh ----
// register offsets, field positions and reset values of the interrupt-request gating block
// assumes byte addressing on an APB bus with 32-bit data
`ifndef IIC_IRQ_GATING_DEFS_VH
`define IIC_IRQ_GATING_DEFS_VH

`define ADDR_IRQ_ENABLE 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_CONFIG 8'h08
`define ADDR_EVENT_STATUS 8'h0C
`define ADDR_EVENT_MASK 8'h10

`define BIT_TX_EMPTY_EN 7
`define BIT_TX_END_EN 6
`define BIT_RX_FULL_EN 5
`define BIT_NO_ACK_EN 4

`define BIT_TX_EMPTY_FLAG 7
`define BIT_TX_END_FLAG 6
`define BIT_RX_FULL_FLAG 5
`define BIT_NO_ACK_FLAG 4
`define BIT_ARB_LOST_FLAG 3
`define BIT_DATA_LOST_FLAG 2

`define BIT_SYNC_FORMAT 0

`define EV_WIDTH 6
`define EV_TX_EMPTY 0
`define EV_TX_END 1
`define EV_RX_FULL 2
`define EV_NO_ACK 3
`define EV_ARB_LOST 4
`define EV_DATA_LOST 5

`define RESET_IRQ_ENABLE 8'h00
`define RESET_STATUS 8'h00
`define RESET_EVENT_MASK 6'h00
`define STATUS_USED_BITS 8'hFC

`endif

// ---- src/iic_interrupt_request_gating.v ----
// interrupt-request gating of a two-wire serial unit: enables, status flags, requests, apb slave
// assumes event inputs are one-cycle pulses from the shift engine on the same clock
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "iic_irq_gating_defs.vh"

// Behaviour
// - transmit-empty request stays inactive while its enable is 0
// - in bus format transmit-end request raised at ninth clock rise when empty flag is 1
// - transmit-end request drops when its flag or enable is cleared
// - receive-full request raised once received word sets buffer-full flag
// - in clocked format receive enable also gates the overrun error request
// - receive-full request drops when its flag or enable is cleared
// - no-ack request raised by no-ack or arbitration-lost flag when enabled
// - in clocked format no-ack enable also gates the overrun error request
// - no-ack request drops when no-ack, arbitration-lost and overrun flags are all cleared or enable cleared
// - transmit-empty request follows empty flag and its enable
// - empty flag set when tx buffer word moves into shift register
// - in bus format transmit-end flag set at ninth clock rise if empty
module iic_interrupt_request_gating (
  input wire i_clock,
  input wire i_reset_n,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire [31:0] o_prdata,
  output wire o_pready,
  output wire o_pslverr,
  input wire i_tx_to_shift,
  input wire i_tx_buffer_write,
  input wire i_ninth_clock_rise,
  input wire i_final_bit_sent,
  input wire i_rx_to_buffer,
  input wire i_rx_buffer_read,
  input wire i_no_ack_detected,
  input wire i_arbitration_lost,
  input wire i_overrun,
  output wire o_sync_format,
  output wire o_tx_empty_irq,
  output wire o_tx_end_irq,
  output wire o_rx_full_irq,
  output wire o_no_ack_irq,
  output wire o_error_irq,
  output wire o_irq
);

  reg [7:0] irq_enable_q;
  reg [7:0] irq_enable_d;

  reg [7:0] status_q;
  wire [7:0] status_d;
  reg [7:0] seen_one_q;
  wire [7:0] seen_one_d;

  reg sync_format_q;
  reg sync_format_d;

  reg [`EV_WIDTH-1:0] event_q;
  wire [`EV_WIDTH-1:0] event_d;
  reg [`EV_WIDTH-1:0] mask_q;
  reg [`EV_WIDTH-1:0] mask_d;

  reg [31:0] prdata_q;
  reg [31:0] prdata_d;
  reg decode_hit;
  reg set_tx_end;

  // apb phases
  wire setup = i_psel & ~i_penable;
  wire access = i_psel & i_penable;
  wire wr = access & i_pwrite;
  wire rd = access & ~i_pwrite;

  // one strobe per register access that changes state
  wire wr_enable = wr & (i_paddr == `ADDR_IRQ_ENABLE);
  wire wr_status = wr & (i_paddr == `ADDR_STATUS);
  wire rd_status = rd & (i_paddr == `ADDR_STATUS);
  wire wr_config = wr & (i_paddr == `ADDR_CONFIG);
  wire rd_event = rd & (i_paddr == `ADDR_EVENT_STATUS);
  wire wr_mask = wr & (i_paddr == `ADDR_EVENT_MASK);

  // enable bits of the irq enable register
  wire tx_empty_en = irq_enable_q[`BIT_TX_EMPTY_EN];
  wire tx_end_en = irq_enable_q[`BIT_TX_END_EN];
  wire rx_full_en = irq_enable_q[`BIT_RX_FULL_EN];
  wire no_ack_en = irq_enable_q[`BIT_NO_ACK_EN];

  // flags of the status register
  wire tx_empty_flag = status_q[`BIT_TX_EMPTY_FLAG];
  wire tx_end_flag = status_q[`BIT_TX_END_FLAG];
  wire rx_full_flag = status_q[`BIT_RX_FULL_FLAG];
  wire no_ack_flag = status_q[`BIT_NO_ACK_FLAG];
  wire arb_lost_flag = status_q[`BIT_ARB_LOST_FLAG];
  wire data_lost_flag = status_q[`BIT_DATA_LOST_FLAG];

  // hardware flag set events
  wire set_tx_empty = i_tx_to_shift;
  wire set_rx_full = i_rx_to_buffer;
  wire set_no_ack = i_no_ack_detected;
  wire set_arb_lost = i_arbitration_lost;
  wire set_data_lost = i_overrun;

  // bus format looks at the registered empty flag when the ninth clock rises
  always @*
  begin
    if (sync_format_q)
    begin
      set_tx_end = i_final_bit_sent;
    end
    else
    begin
      set_tx_end = i_ninth_clock_rise & tx_empty_flag;
    end
  end

  wire [7:0] flag_set = {set_tx_empty, set_tx_end, set_rx_full, set_no_ack, set_arb_lost, set_data_lost, 2'b00};
  wire [`EV_WIDTH-1:0] event_set = {set_data_lost, set_arb_lost, set_no_ack, set_rx_full, set_tx_end, set_tx_empty};

  // tx buffer writes and rx buffer reads also clear flags
  wire [7:0] hw_clear = {i_tx_buffer_write, i_tx_buffer_write, i_rx_buffer_read, 5'h00};
  wire [7:0] used_bits = `STATUS_USED_BITS;
  wire [7:0] reset_status = `RESET_STATUS;

  // read words, unused upper bits read as 0
  wire [31:0] word_enable = {24'h000000, irq_enable_q};
  wire [31:0] word_status = {24'h000000, status_q};
  wire [31:0] word_config = {31'h0, sync_format_q};
  wire [31:0] word_event = {{(32-`EV_WIDTH){1'b0}}, event_q};
  wire [31:0] word_mask = {{(32-`EV_WIDTH){1'b0}}, mask_q};

  always @*
  begin
    case (i_paddr)
      `ADDR_IRQ_ENABLE: decode_hit = 1'b1;
      `ADDR_STATUS: decode_hit = 1'b1;
      `ADDR_CONFIG: decode_hit = 1'b1;
      `ADDR_EVENT_STATUS: decode_hit = 1'b1;
      `ADDR_EVENT_MASK: decode_hit = 1'b1;
      default: decode_hit = 1'b0;
    endcase
  end

  // read data is loaded in the setup cycle and stands through the access phase
  always @*
  begin
    if (setup)
    begin
      case (i_paddr)
        `ADDR_IRQ_ENABLE: prdata_d = word_enable;
        `ADDR_STATUS: prdata_d = word_status;
        `ADDR_CONFIG: prdata_d = word_config;
        `ADDR_EVENT_STATUS: prdata_d = word_event;
        `ADDR_EVENT_MASK: prdata_d = word_mask;
        default: prdata_d = 32'h00000000;
      endcase
    end
    else
    begin
      prdata_d = prdata_q;
    end
  end

  // irq enable register, written as a whole byte
  always @*
  begin
    if (wr_enable)
    begin
      irq_enable_d = i_pwdata[7:0];
    end
    else
    begin
      irq_enable_d = irq_enable_q;
    end
  end

  // format select: 1 is the clocked synchronous format
  always @*
  begin
    if (wr_config)
    begin
      sync_format_d = i_pwdata[`BIT_SYNC_FORMAT];
    end
    else
    begin
      sync_format_d = sync_format_q;
    end
  end

  // mask of the sticky events behind the summary interrupt
  always @*
  begin
    if (wr_mask)
    begin
      mask_d = i_pwdata[`EV_WIDTH-1:0];
    end
    else
    begin
      mask_d = mask_q;
    end
  end

  genvar b;

  // a flag clears by writing 0 after it was read as 1; a hardware set in the same cycle wins
  generate
    for (b = 0; b < 8; b = b + 1)
    begin : g_status_bit
      wire sw_clear = wr_status & seen_one_q[b] & ~i_pwdata[b];
      wire kept = status_q[b] & ~(sw_clear | hw_clear[b]);
      wire seen_wr = seen_one_q[b] & i_pwdata[b];
      wire seen_rd = seen_one_q[b] | status_q[b];
      wire seen_next = wr_status ? seen_wr : (rd_status ? seen_rd : seen_one_q[b]);
      assign status_d[b] = used_bits[b] & (kept | flag_set[b]);
      assign seen_one_d[b] = seen_next & status_d[b];

      always @(posedge i_clock)
      begin
        if (!i_reset_n)
        begin
          status_q[b] <= reset_status[b];
        end
        else
        begin
          status_q[b] <= status_d[b];
        end
      end

      // remembers which flags software has read as 1
      always @(posedge i_clock)
      begin
        if (!i_reset_n)
        begin
          seen_one_q[b] <= 1'b0;
        end
        else
        begin
          seen_one_q[b] <= seen_one_d[b];
        end
      end
    end
  endgenerate

  // sticky events: a read clears them, a new event in the same cycle wins
  generate
    for (b = 0; b < `EV_WIDTH; b = b + 1)
    begin : g_event_bit
      assign event_d[b] = (event_q[b] & ~rd_event) | event_set[b];

      always @(posedge i_clock)
      begin
        if (!i_reset_n)
        begin
          event_q[b] <= 1'b0;
        end
        else
        begin
          event_q[b] <= event_d[b];
        end
      end
    end
  endgenerate

  // enables reset to 0, so no request can stand after reset
  always @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      irq_enable_q <= `RESET_IRQ_ENABLE;
    end
    else
    begin
      irq_enable_q <= irq_enable_d;
    end
  end

  // format select
  always @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      sync_format_q <= 1'b0;
    end
    else
    begin
      sync_format_q <= sync_format_d;
    end
  end

  // event mask
  always @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      mask_q <= `RESET_EVENT_MASK;
    end
    else
    begin
      mask_q <= mask_d;
    end
  end

  // read data register
  always @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      prdata_q <= 32'h00000000;
    end
    else
    begin
      prdata_q <= prdata_d;
    end
  end

  // apb answer: no wait states, error on an unmapped access
  wire bad_access = access & ~decode_hit;
  assign o_prdata = prdata_q;
  assign o_pready = 1'b1;
  assign o_pslverr = bad_access;
  assign o_sync_format = sync_format_q;

  // flag conditions behind each request
  wire tx_empty_cond = tx_empty_flag;
  wire tx_end_cond = tx_end_flag;
  wire rx_full_cond = rx_full_flag;
  wire no_ack_cond = no_ack_flag | arb_lost_flag | (sync_format_q & data_lost_flag);
  wire error_cond = sync_format_q & data_lost_flag;

  // request levels: flag condition AND enable, withdrawn once either is cleared
  assign o_tx_empty_irq = tx_empty_en & tx_empty_cond;
  assign o_tx_end_irq = tx_end_en & tx_end_cond;
  assign o_rx_full_irq = rx_full_en & rx_full_cond;
  assign o_no_ack_irq = no_ack_en & no_ack_cond;
  // overrun error needs both receive and no-ack enables in clocked format
  assign o_error_irq = error_cond & rx_full_en & no_ack_en;

  // summary interrupt from the sticky events under the mask
  assign o_irq = |(event_q & mask_q);

endmodule // iic_interrupt_request_gating
`default_nettype wire

// ---- test/iic_irq_monitor.sv ----
// checker: request outputs tied to event pulses and register writes
// bound to the gating block, single clock
`timescale 1ns/10ps
`default_nettype none
module iic_irq_monitor (input wire i_clock, i_reset_n, i_psel, i_penable, i_pwrite, i_tx_to_shift, i_tx_buffer_write,
  i_ninth_clock_rise, i_final_bit_sent, i_rx_to_buffer, i_rx_buffer_read, i_no_ack_detected, i_arbitration_lost,
  i_overrun, o_sync_format, o_tx_empty_irq, o_tx_end_irq, o_rx_full_irq, o_no_ack_irq, o_error_irq, o_irq);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  wire wr = i_psel & i_penable & i_pwrite;
  a_tx_empty_rise: assert property ($rose(o_tx_empty_irq) |-> $past(i_tx_to_shift | wr))
    else $error("tx empty rose alone");
  a_tx_empty_drop: assert property (o_tx_empty_irq && i_tx_buffer_write && !i_tx_to_shift |=> !o_tx_empty_irq)
    else $error("tx empty stuck");
  a_tx_end_rise: assert property ($rose(o_tx_end_irq) |-> $past(i_ninth_clock_rise | i_final_bit_sent | wr))
    else $error("tx end rose alone");
  a_tx_end_drop: assert property (o_tx_end_irq && i_tx_buffer_write && !i_ninth_clock_rise && !i_final_bit_sent
    |=> !o_tx_end_irq) else $error("tx end stuck");
  a_rx_full_rise: assert property ($rose(o_rx_full_irq) |-> $past(i_rx_to_buffer | wr))
    else $error("rx full rose alone");
  a_rx_full_drop: assert property (o_rx_full_irq && i_rx_buffer_read && !i_rx_to_buffer |=> !o_rx_full_irq)
    else $error("rx full stuck");
  a_no_ack_rise: assert property ($rose(o_no_ack_irq)
    |-> $past(i_no_ack_detected | i_arbitration_lost | i_overrun | wr)) else $error("no ack rose alone");
  a_error_gate: assert property (o_error_irq |-> o_sync_format && o_no_ack_irq)
    else $error("error request ungated");
  a_reset_quiet: assert property ($rose(i_reset_n) |-> !(o_tx_empty_irq | o_tx_end_irq | o_rx_full_irq | o_no_ack_irq
    | o_error_irq | o_irq)) else $error("request after reset");
endmodule // iic_irq_monitor
bind iic_interrupt_request_gating iic_irq_monitor mon (.*);
`default_nettype wire

// ---- test/irq_host_model.sv ----
// host side: samples the request levels as an interrupt controller would
// assumes level requests on the block clock
`timescale 1ns/10ps
`default_nettype none
module irq_host_model (input wire logic i_clock, input wire logic [5:0] i_req, output logic [5:0] o_taken);
  always @(posedge i_clock) o_taken <= i_req;
endmodule // irq_host_model
`default_nettype wire

// ---- test/iic_interrupt_request_gating_bench.sv ----
// bench: random enables, format, mask and event pulses against a flag model
// apb task waits out any wait states on pready; assumes one-cycle event pulses
`timescale 1ns/10ps
`default_nettype none
module iic_interrupt_request_gating_bench;
  logic i_clock = 0, i_reset_n = 0, i_psel = 0, i_penable = 0, i_pwrite = 0, sy, te, tf, rx, nk, al, ov, er;
  logic [7:0] i_paddr = 0, en;
  logic [31:0] i_pwdata = 0, rd;
  logic [8:0] pin = 0;
  logic [5:0] msk, ev;
  wire i_tx_to_shift = pin[0], i_tx_buffer_write = pin[1], i_ninth_clock_rise = pin[2], i_final_bit_sent = pin[3];
  wire i_rx_to_buffer = pin[4], i_rx_buffer_read = pin[5], i_no_ack_detected = pin[6], i_arbitration_lost = pin[7];
  wire i_overrun = pin[8];
  wire [31:0] o_prdata;
  wire o_pready, o_pslverr, o_sync_format, o_tx_empty_irq, o_tx_end_irq, o_rx_full_irq, o_no_ack_irq, o_error_irq, o_irq;
  wire [5:0] taken;
  int err_total = 0, total_checks = 0;
  always #20 i_clock = ~i_clock;
  iic_interrupt_request_gating uut (.*);
  irq_host_model host (.i_clock, .i_req({o_irq, o_error_irq, o_no_ack_irq, o_rx_full_irq, o_tx_end_irq, o_tx_empty_irq}),
    .o_taken(taken));
  task chk(input [31:0] g, x);
    total_checks++;
    if (g !== x)
    begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    @(posedge i_clock);
    {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {2'h2, w, a, d};
    @(posedge i_clock);
    i_penable <= 1'h1;
    do @(posedge i_clock); while (o_pready !== 1'b1);
    rd = o_prdata;
    er = o_pslverr;
    {i_psel, i_penable} <= 2'h0;
  endtask
  task chk_irq;
    chk(taken, {|(ev & msk), sy & ov & en[5] & en[4], en[4] & (nk | al | sy & ov), en[5] & rx, en[6] & tf, en[7] & te});
  endtask
  task end_of_test;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    #200000;
    err_total++;
    end_of_test;
  end
  initial
  begin
    logic [8:0] p;
    logic [7:0] c;
    void'($urandom(37));
    {te, tf, rx, nk, al, ov, ev} = 0;
    repeat (4) @(posedge i_clock);
    i_reset_n <= 1'h1;
    apb(0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    chk(taken, 32'h0);
    apb(0, 8'h14, 32'h0);
    chk({er, rd[30:0]}, 32'h80000000);
    repeat (40)
    begin
      en = $urandom;
      sy = $urandom;
      msk = $urandom;
      p = $urandom;
      apb(1, 8'h00, en);
      apb(1, 8'h08, sy);
      apb(1, 8'h10, msk);
      pin <= {p[8:4], p[3] & sy, p[2] & !sy, p[1:0]};
      ev |= {p[8:6], p[4], p[2] & !sy & te | p[3] & sy, p[0]};
      tf = tf & !p[1] | p[2] & !sy & te | p[3] & sy;
      te = te & !p[1] | p[0];
      rx = rx & !p[5] | p[4];
      {nk, al, ov} |= {p[6], p[7], p[8]};
      @(posedge i_clock);
      pin <= 9'h000;
      repeat (2) @(posedge i_clock);
      @(negedge i_clock);
      chk_irq;
      apb(0, 8'h0C, 32'h0);
      chk(rd, ev);
      ev = 0;
      apb(0, 8'h00, 32'h0);
      chk(rd, en);
      chk(o_sync_format, sy);
      apb(0, 8'h04, 32'h0);
      chk(rd, {te, tf, rx, nk, al, ov, 2'b00});
      c = $urandom;
      apb(1, 8'h04, ~c);
      {te, tf, rx, nk, al, ov} = {te, tf, rx, nk, al, ov} & ~c[7:2];
      repeat (2) @(posedge i_clock);
      @(negedge i_clock);
      chk_irq;
    end
    end_of_test;
  end
endmodule // iic_interrupt_request_gating_bench
`default_nettype wire
